// File: core/bsw_span_writer.sv
// block-stipple span writer: one host write becomes masked vram block-write cycles
`timescale 1ns/10ps

module bsw_span_writer
   import bsw_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                rst_n_i,
   // host drawing writes
   input  wire logic                fb_wr_i,
   input  wire logic [ADDR_W-1:0]   fb_addr_i,
   input  wire logic [MASK_W-1:0]   fb_data_i,
   input  wire logic                span_resume_i,
   output      logic                req_ready_o,
   output      logic                cfg_error_o,
   // configuration levels
   input  wire logic [ADDR_W-1:0]   pixel_address_reg_i,
   input  wire logic [MASK_W-1:0]   plane_write_mask_reg_i,
   input  wire logic [ROP_W-1:0]    raster_op_reg_i,
   input  wire logic                fb_depth32_i,
   // vram block-write cycles
   output      logic                mem_bw_valid_o,
   input  wire logic                mem_ready_i,
   output      logic [GRP_W-1:0]    mem_bw_addr_o,
   output      logic [MASK_W-1:0]   mem_bw_pix_en_o,
   output      logic [MASK_W-1:0]   mem_plane_mask_o,
   output      logic [1:0]          mem_dest_bmp_o,
   output      logic [1:0]          mem_dest_byte_o
);

   // every property below lives on the one clock and is off while reset is low
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   // ==========================================================
   // request decode
   logic                req_any;
   logic                accept;
   logic                accept_ok;
   logic                accept_bad;
   logic [1:0]          req_bmp;
   logic                req_packed8;
   logic                req_wide;
   logic [ADDR_W-1:0]   req_byte;
   logic [ADDR_W-1:0]   req_pix;
   logic [4:0]          req_rot;
   logic [2*MASK_W-1:0] req_win;
   logic                req_unsup;
   logic                req_misalign;

   // raster-op bits 7:0 are deliberately never looked at
   assign req_bmp     = raster_op_reg_i[DBMP_LSB+1:DBMP_LSB];
   assign req_packed8 = (req_bmp == DBMP_PACKED8);
   assign req_wide    = (req_bmp == DBMP_12BPP) || (req_bmp == DBMP_24BPP);
   assign req_any     = fb_wr_i | span_resume_i;
   assign accept      = req_any & req_ready_o;

   // a frame buffer write is dword aligned, only the resume path carries byte bits
   assign req_byte = fb_wr_i ? {fb_addr_i[ADDR_W-1:2], 2'b00}
                             : pixel_address_reg_i;

   // packed 8-bit on an 8-bit buffer is byte addressed, all else dword addressed
   assign req_pix = (req_packed8 && !fb_depth32_i) ? req_byte
                                                   : {2'b00, req_byte[ADDR_W-1:2]};

   // packed 8-bit into a 32-bit buffer cannot be drawn
   assign req_unsup    = req_packed8 && fb_depth32_i;
   // a direct write cannot reach a byte inside a dword
   assign req_misalign = fb_wr_i && req_packed8 && (fb_addr_i[1:0] != 2'b00);
   assign accept_bad   = accept && (req_unsup || req_misalign);
   assign accept_ok    = accept && !accept_bad;

   // the host already placed bit 0 on the quad start; finish the job to 32 pixels
   assign req_rot = {req_pix[4:2], 2'b00};
   assign req_win = {MASK_ZERO, fb_data_i} << req_rot;

   // ==========================================================
   // captured span
   logic [MASK_W-1:0]   pend_lo_reg;
   logic [MASK_W-1:0]   pend_lo_next;
   logic [MASK_W-1:0]   pend_hi_reg;
   logic [MASK_W-1:0]   pend_hi_next;
   logic [GRP_W-1:0]    grp_reg;
   logic                fb32_reg;
   logic                wide_reg;
   bsw_state_t          state_reg;
   bsw_state_t          state_next;
   logic [CNT_W-1:0]    cyc_cnt_reg;

   // ==========================================================
   // chunk selection
   logic                use_hi;
   logic [MASK_W-1:0]   cur;
   logic                split;
   logic [QUADS-1:0]    quad_nz;
   logic [QUADS-1:0]    quad_low;
   logic [MASK_W-1:0]   quad_mask;
   logic [MASK_W-1:0]   chunk;
   logic                pend_any;
   logic                slot_free;
   logic                load_chunk;

   assign pend_any   = (pend_lo_reg != MASK_ZERO) || (pend_hi_reg != MASK_ZERO);
   assign slot_free  = !mem_bw_valid_o || mem_ready_i;
   assign load_chunk = (state_reg == BSW_RUN) && pend_any && slot_free;

   // empty groups are never visited, so an unsplit one-sided span costs one cycle
   assign use_hi = (pend_lo_reg == MASK_ZERO);
   assign cur    = use_hi ? pend_hi_reg : pend_lo_reg;

   // wide pixels in a 32-bit buffer take one cycle per lit quad unless full
   assign split = fb32_reg && wide_reg && (cur != MASK_ONES);

   // per-quad occupancy and per-pixel expansion of the lowest lit quad
   genvar gq;
   generate
      for (gq = 0; gq < QUADS; gq++) begin : g_quad
         assign quad_nz[gq] = |cur[gq*QUAD_PIX +: QUAD_PIX];
         assign quad_mask[gq*QUAD_PIX +: QUAD_PIX] = {QUAD_PIX{quad_low[gq]}};
      end
   endgenerate

   assign quad_low = quad_nz & (QUADS'(~quad_nz) + 8'h01);
   // an 8-bit buffer or a full group goes out whole: at most one cycle per group
   assign chunk    = split ? (cur & quad_mask) : cur;

   // pending bits left once the chunk is issued
   always_comb begin
      pend_lo_next = pend_lo_reg;
      pend_hi_next = pend_hi_reg;
      if (accept_ok) begin
         pend_lo_next = req_win[MASK_W-1:0];
         pend_hi_next = req_win[2*MASK_W-1:MASK_W];
      end else if (load_chunk) begin
         if (use_hi) begin
            pend_hi_next = pend_hi_reg & ~chunk;
         end else begin
            pend_lo_next = pend_lo_reg & ~chunk;
         end
      end
   end

   // ==========================================================
   // sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         BSW_IDLE: begin
            // an all-zero mask draws nothing and never leaves idle
            if (accept_ok && (fb_data_i != MASK_ZERO)) begin
               state_next = BSW_RUN;
            end
         end
         BSW_RUN: begin
            if (!pend_any && slot_free) begin
               state_next = BSW_IDLE;
            end
         end
         default: begin
            state_next = BSW_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= BSW_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ready only in idle: a span is fully issued before the next is taken
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_ready_o <= 1'b0;
      end else begin
         req_ready_o <= (state_next == BSW_IDLE);
      end
   end

   // refused request shows as a one-cycle pulse and draws nothing
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_error_o <= 1'b0;
      end else begin
         cfg_error_o <= accept_bad;
      end
   end

   // pending masks
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_lo_reg <= MASK_ZERO;
         pend_hi_reg <= MASK_ZERO;
      end else begin
         pend_lo_reg <= pend_lo_next;
         pend_hi_reg <= pend_hi_next;
      end
   end

   // span parameters are frozen at accept so host updates cannot tear a span
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         grp_reg          <= GRP_RST;
         fb32_reg         <= 1'b0;
         wide_reg         <= 1'b0;
         mem_plane_mask_o <= MASK_ZERO;
         mem_dest_bmp_o   <= FIELD_RST;
         mem_dest_byte_o  <= FIELD_RST;
      end else if (accept_ok) begin
         grp_reg          <= req_pix[ADDR_W-1:5];
         fb32_reg         <= fb_depth32_i;
         wide_reg         <= req_wide;
         mem_plane_mask_o <= plane_write_mask_reg_i;
         mem_dest_bmp_o   <= req_bmp;
         mem_dest_byte_o  <= raster_op_reg_i[DBYTE_LSB+1:DBYTE_LSB];
      end
   end

   // ==========================================================
   // block-write output stage
   // groups are 32-pixel aligned, so the vram colour registers tile on pixel[2:0]
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_bw_valid_o  <= 1'b0;
         mem_bw_addr_o   <= GRP_RST;
         mem_bw_pix_en_o <= MASK_ZERO;
      end else if (load_chunk) begin
         mem_bw_valid_o  <= 1'b1;
         mem_bw_addr_o   <= use_hi ? (grp_reg + 19'h00001) : grp_reg;
         mem_bw_pix_en_o <= chunk;
      end else if (mem_ready_i) begin
         mem_bw_valid_o  <= 1'b0;
      end
   end

   // cycles spent on the current span, checked against the ceilings
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc_cnt_reg <= CNT_RST;
      end else if (accept_ok) begin
         cyc_cnt_reg <= CNT_RST;
      end else if (load_chunk) begin
         cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
      end
   end

   // ==========================================================
   // assertions
   a_hold_off_busy: assert property (
      accept_ok && (fb_data_i != MASK_ZERO) |=> !req_ready_o [*2])
      else $error("ready returned while a span was still pending");

   a_cycle_stable: assert property (
      mem_bw_valid_o && !mem_ready_i |=>
         mem_bw_valid_o && $stable(mem_bw_pix_en_o) && $stable(mem_bw_addr_o)
         && $stable(mem_plane_mask_o))
      else $error("block-write cycle changed before it was taken");

   a_no_empty_write: assert property (
      mem_bw_valid_o |-> (mem_bw_pix_en_o != MASK_ZERO))
      else $error("block-write cycle issued with no pixel enabled");

   a_two_cycles_8bit: assert property (
      load_chunk && !(fb32_reg && wide_reg) |-> (cyc_cnt_reg < MAX_CYC_8BIT))
      else $error("8-bit span took more than two write cycles");

   a_eight_cycles_wide: assert property (
      load_chunk |-> (cyc_cnt_reg < MAX_CYC_WIDE))
      else $error("span took more than eight write cycles");

   a_refused_no_draw: assert property (
      accept && req_unsup |=> cfg_error_o && !mem_bw_valid_o ##1 !mem_bw_valid_o)
      else $error("unsupported bitmap request was drawn");

   a_aligned_single: assert property (
      accept_ok && (fb_data_i == MASK_ONES) && (req_pix[4:0] == 5'h00) |->
         ##2 (mem_bw_valid_o && (mem_bw_pix_en_o == MASK_ONES)
              && (mem_bw_addr_o == $past(req_pix[ADDR_W-1:5], 2)))
         ##1 (!mem_bw_valid_o || $stable(mem_bw_pix_en_o)))
      else $error("aligned full span did not go out as one cycle");

   a_zero_mask_skip: assert property (
      accept_ok && (fb_data_i == MASK_ZERO) |=> req_ready_o && !mem_bw_valid_o)
      else $error("all-zero mask caused memory work");

   a_group_window: assert property (
      $rose(mem_bw_valid_o) |->
         (mem_bw_addr_o == grp_reg) || (mem_bw_addr_o == grp_reg + 19'h00001))
      else $error("block write outside the span's two groups");

   c_single_cycle: cover property (
      accept_ok ##2 (mem_bw_valid_o && mem_bw_pix_en_o == MASK_ONES) ##1 req_ready_o);

   c_split_span: cover property (
      load_chunk && !use_hi ##[1:20] load_chunk && use_hi);

   c_quad_split: cover property (load_chunk && split && cyc_cnt_reg == 4'h7);

   c_refused: cover property (cfg_error_o);

endmodule : bsw_span_writer

// File: core/bsw_pkg.sv
// constants and types shared by the block-stipple span writer
package bsw_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W    = 24;   // host byte address width
   localparam int GRP_W     = 19;   // 32-pixel group index width
   localparam int MASK_W    = 32;   // stipple mask and span width in pixels
   localparam int QUADS     = 8;    // 4-pixel quads per 32-pixel group
   localparam int QUAD_PIX  = 4;    // pixels per quad
   localparam int ROP_W     = 12;   // raster-op register bits seen here
   localparam int CNT_W     = 4;    // write-cycle counter width

   // ==========================================================
   // raster-op register fields
   localparam int DBMP_LSB  = 8;    // destination bitmap type, bits 9:8
   localparam int DBYTE_LSB = 10;   // destination byte, bits 11:10

   // destination bitmap type encodings
   localparam logic [1:0] DBMP_PACKED8   = 2'h0;
   localparam logic [1:0] DBMP_UNPACKED8 = 2'h1;
   localparam logic [1:0] DBMP_12BPP     = 2'h2;
   localparam logic [1:0] DBMP_24BPP     = 2'h3;

   // ==========================================================
   // masks and reset values
   localparam logic [MASK_W-1:0] MASK_ONES  = 32'hffffffff;
   localparam logic [MASK_W-1:0] MASK_ZERO  = 32'h00000000;
   localparam logic [GRP_W-1:0]  GRP_RST    = 19'h00000;
   localparam logic [1:0]        FIELD_RST  = 2'h0;
   localparam logic [CNT_W-1:0]  CNT_RST    = 4'h0;

   // write-cycle ceilings per 32-pixel span
   localparam logic [CNT_W-1:0]  MAX_CYC_8BIT = 4'h2;
   localparam logic [CNT_W-1:0]  MAX_CYC_WIDE = 4'h8;

   // ==========================================================
   // sequencer states, gray along idle -> run -> idle
   typedef enum logic [0:0] {
      BSW_IDLE = 1'b0,
      BSW_RUN  = 1'b1
   } bsw_state_t;

endpackage : bsw_pkg

// File: bench/bsw_mem_model.sv
// memory controller model that takes vram block-write cycles
`timescale 1ns/10ps
module bsw_mem_model (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   // pacing and handshake
   input  wire logic slow_i,
   input  wire logic bw_valid_i,
   output      logic ready_o
);
   // ==========================================================
   // ready pacing: a slow memory stalls at random so cycles must be held
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= (slow_i && bw_valid_i) ? ($urandom_range(2) == 0) : 1'b1;
      end
   end
endmodule : bsw_mem_model

// File: bench/block_stipple_span_writer_tb.sv
// self-checking bench for the block-stipple span writer
`timescale 1ns/10ps
module block_stipple_span_writer_tb;
   import bsw_pkg::*;
   // ==========================================================
   // design ports
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, fb_wr_i = 1'b0, span_resume_i = 1'b0;
   logic [ADDR_W-1:0] fb_addr_i = '0, pixel_address_reg_i = '0;
   logic [MASK_W-1:0] fb_data_i = '0, plane_write_mask_reg_i = '0;
   logic [ROP_W-1:0]  raster_op_reg_i = '0;
   logic fb_depth32_i = 1'b0, mem_ready_i, slow = 1'b0, req_ready_o, cfg_error_o, mem_bw_valid_o;
   logic [GRP_W-1:0]  mem_bw_addr_o;
   logic [MASK_W-1:0] mem_bw_pix_en_o, mem_plane_mask_o;
   logic [1:0]        mem_dest_bmp_o, mem_dest_byte_o;
   // expected span: chunk queues plus per-span fields
   logic [GRP_W-1:0]  exp_addr[$];
   logic [MASK_W-1:0] exp_en[$];
   logic [MASK_W-1:0] exp_pm;
   logic [ROP_W-1:0]  exp_rop;
   int errors = 0, samples_checked = 0, cycles = 0;

   always #12.5 ref_clk_i = ~ref_clk_i;

   bsw_span_writer i_bsw_span_writer (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .fb_wr_i(fb_wr_i), .fb_addr_i(fb_addr_i), .fb_data_i(fb_data_i),
      .span_resume_i(span_resume_i), .req_ready_o(req_ready_o), .cfg_error_o(cfg_error_o),
      .pixel_address_reg_i(pixel_address_reg_i), .plane_write_mask_reg_i(plane_write_mask_reg_i),
      .raster_op_reg_i(raster_op_reg_i), .fb_depth32_i(fb_depth32_i),
      .mem_bw_valid_o(mem_bw_valid_o), .mem_ready_i(mem_ready_i), .mem_bw_addr_o(mem_bw_addr_o),
      .mem_bw_pix_en_o(mem_bw_pix_en_o), .mem_plane_mask_o(mem_plane_mask_o),
      .mem_dest_bmp_o(mem_dest_bmp_o), .mem_dest_byte_o(mem_dest_byte_o));
   bsw_mem_model i_bsw_mem_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
      .bw_valid_i(mem_bw_valid_o), .ready_o(mem_ready_i));

   task automatic check(input bit ok, input string what);
      samples_checked++;
      if (!ok) begin
         errors++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // hang guard, sized well above the whole run
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   // every taken block-write cycle is compared with the reference queue
   always @(posedge ref_clk_i) begin
      if (rst_n_i && mem_bw_valid_o === 1'b1 && mem_ready_i === 1'b1) begin
         if (exp_addr.size() == 0) check(1'b0, "extra write cycle");
         else begin
            check(mem_bw_addr_o === exp_addr[0], "group address");
            check(mem_bw_pix_en_o === exp_en[0], "pixel enables");
            check(mem_plane_mask_o === exp_pm, "plane mask");
            check({mem_dest_byte_o, mem_dest_bmp_o} === exp_rop[11:8], "dest fields");
            void'(exp_addr.pop_front());
            void'(exp_en.pop_front());
         end
      end
   end

   // reference chunking: quads only for wide bitmaps in a 32-bpp buffer
   task automatic plan(input logic [ADDR_W-1:0] pix, input logic [31:0] m, input bit quads);
      logic [63:0] w;
      logic [31:0] gm;
      w = {32'h00000000, m} << (int'(pix[4:2]) * 4);
      for (int h = 0; h < 2; h++) begin
         gm = w[h*32 +: 32];
         if (gm != 32'h00000000 && quads && gm != 32'hffffffff) begin
            for (int q = 0; q < 8; q++) begin
               if (gm[q*4 +: 4] != 4'h0) begin
                  exp_addr.push_back(pix[23:5] + 19'(h));
                  exp_en.push_back(gm & (32'h0000000f << (q * 4)));
               end
            end
         end else if (gm != 32'h00000000) begin
            exp_addr.push_back(pix[23:5] + 19'(h));
            exp_en.push_back(gm);
         end
      end
   endtask : plan

   // one host request; the whole raster op, the plane mask and the mask data drift after accept
   task automatic do_req(input bit res, input logic [23:0] a, input logic [31:0] m,
                         input logic [1:0] dt, input bit d32);
      bit err;
      bit busy;
      int n;
      err = (dt == DBMP_PACKED8 && d32) || (!res && dt == DBMP_PACKED8 && a[1:0] != 2'h0);
      if (!err) plan((dt == DBMP_PACKED8 && !d32) ? a : (a >> 2), m, d32 && dt[1]);
      busy = exp_addr.size() != 0;
      @(posedge ref_clk_i);
      while (req_ready_o !== 1'b1) @(posedge ref_clk_i);
      exp_pm = $urandom;
      exp_rop = {2'($urandom), dt, 8'($urandom)};
      fb_wr_i <= !res;
      span_resume_i <= res;
      fb_addr_i <= res ? 24'($urandom) : a;
      pixel_address_reg_i <= res ? a : 24'($urandom);
      fb_data_i <= m;
      plane_write_mask_reg_i <= exp_pm;
      raster_op_reg_i <= exp_rop;
      fb_depth32_i <= d32;
      @(posedge ref_clk_i);
      plane_write_mask_reg_i <= $urandom;
      raster_op_reg_i <= 12'($urandom);
      fb_data_i <= ~m;
      if (!busy) {fb_wr_i, span_resume_i} <= 2'h0;
      #1;
      check(cfg_error_o === err, "refusal flag");
      check(req_ready_o === !busy, "ready after accept");
      // a strobe held while busy must be ignored
      if (busy) @(posedge ref_clk_i) {fb_wr_i, span_resume_i} <= 2'h0;
      n = 0;
      while (n < 300 && !(req_ready_o === 1'b1 && exp_addr.size() == 0)) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check(exp_addr.size() == 0 && req_ready_o === 1'b1, "span not finished");
   endtask : do_req

   // ==========================================================
   // main sequence: every bitmap type, both depths, both memory paces
   initial begin
      logic [31:0] masks[6];
      logic [23:0] a;
      void'($urandom(99));
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      #1;
      // no edge has passed since the release, so every output still shows reset
      check(req_ready_o === 1'b0 && mem_bw_valid_o === 1'b0 && cfg_error_o === 1'b0,
            "reset outputs");
      for (int s = 0; s < 2; s++) begin
         for (int d = 0; d < 2; d++) begin
            for (int dt = 0; dt < 4; dt++) begin
               masks = '{32'hffffffff, 32'h00000000, $urandom, 32'h80000001,
                         32'h0ff00ff0, $urandom};
               for (int mi = 0; mi < 6; mi++) begin
                  slow <= s[0];
                  a = 24'($urandom);
                  if (mi % 2 == 0) a[6:0] = 7'h00;
                  else if (!(dt == 0 && mi == 3)) a[1:0] = 2'h0;
                  do_req(dt == 0 && d == 0 && mi == 5, a, masks[mi], 2'(dt), d[0]);
               end
            end
         end
      end
      report_and_stop();
   end
endmodule : block_stipple_span_writer_tb
